//--- inc/dpram_pkg.sv
// Package for the dual-port synchronous RAM port model and its host controller.
// Assumes one clock (i_clk) shared by both ports and by the host.
package dpram_pkg;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int ADDR_W = 18;
  localparam int DEPTH = 1 << ADDR_W;
  // Cross-port skew figure and its cycle count; with one shared clock the
  // 6 ns skew is under one 8 ns period, so it rounds up to a single cycle.
  localparam int CLK_PERIOD_NS = 8;
  localparam int CROSS_PORT_CLOCK_SKEW_NS = 6;
  localparam int SKEW_CYCLES = (CROSS_PORT_CLOCK_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [ADDR_W-1:0] MASK_RESET = 18'h3ffff;
  localparam logic [ADDR_W-1:0] MAILBOX_ADDR = 18'h3ffff;
  localparam logic [ADDR_W-1:0] WRAP_ADDR_HI = 18'h3ffff;
  localparam logic [ADDR_W-1:0] WRAP_ADDR_LO = 18'h3fffe;
  typedef enum logic [1:0] {HOST_IDLE, HOST_ACCESS, HOST_TURN} host_state_t;
endpackage : dpram_pkg

//--- inc/dpram_if.sv
// Pin-level interface of one RAM port; device and host ends join here.
// Assumes the testbench resolves the two-way pins from the enables.
`timescale 1ns/1ps
interface dpram_if;
  import dpram_pkg::*;
  logic primary_select_n;
  logic secondary_select;
  logic rw;
  logic oe_n;
  logic address_strobe_n;
  logic counter_advance_n;
  logic counter_clear_n;
  logic counter_or_mask_select;
  logic byte_lane_select_low_n;
  logic byte_lane_select_high_n;
  logic global_reset_n;
  logic [ADDR_W-1:0] addr_host;
  logic addr_host_oe;
  logic [ADDR_W-1:0] addr_dev;
  logic addr_dev_oe;
  logic readback;
  logic [DATA_W-1:0] dq_host;
  logic dq_host_oe;
  logic [DATA_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic wrap_flag_n;
  logic mail_flag_n;
  modport device (
    input primary_select_n, secondary_select, rw, oe_n, address_strobe_n, counter_advance_n,
    input counter_clear_n, counter_or_mask_select, byte_lane_select_low_n,
    input byte_lane_select_high_n, global_reset_n, addr_host, dq_host, readback,
    output addr_dev, addr_dev_oe, dq_dev, dq_dev_oe, wrap_flag_n, mail_flag_n
  );
  modport host (
    output primary_select_n, secondary_select, rw, oe_n, address_strobe_n, counter_advance_n,
    output counter_clear_n, counter_or_mask_select, byte_lane_select_low_n,
    output byte_lane_select_high_n, global_reset_n, addr_host, addr_host_oe, dq_host,
    output dq_host_oe, readback,
    input addr_dev, addr_dev_oe, dq_dev, dq_dev_oe, wrap_flag_n, mail_flag_n
  );
endinterface : dpram_if

//--- hw/dpram_port.sv
// Dual-port RAM: two pin-level ports over one shared array, counter per port.
// Assumes both ports clocked by i_clk; pa is the writer side of the mailbox.
`timescale 1ns/1ps
module dpram_core
  import dpram_pkg::*;
#(
  parameter int AW = ADDR_W // Implemented address bits
) (
  input wire logic i_clk, // Common clock
  input wire logic i_rst_b, // Async reset, active low
  dpram_if.device pa, // Port A pins
  dpram_if.device pb // Port B pins
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic rst_b;
  assign rst_b = i_rst_b & pa.global_reset_n & pb.global_reset_n;

  function automatic logic sel(input logic n0, input logic s1);
    return !n0 && s1;
  endfunction : sel

  // Per-port state in arrays so the two ports share one generate body.
  logic [1:0][ADDR_W-1:0] cnt_ff, load_ff, mask_ff;
  logic [1:0] rd_ff, prev_we_ff, rb_ff, wrap_n_ff;
  logic [1:0][DATA_W-1:0] dout_ff;
  logic [1:0][ADDR_W-1:0] rb_val_ff;
  logic [1:0] we;
  logic [1:0][ADDR_W-1:0] acc;
  logic [1:0][DATA_W-1:0] din;
  logic [1:0][1:0] lane_n;
  logic mail_n_ff;

  logic [1:0] cs, rwv, oen, adsn, cntn, clrn, cms, rbk;
  logic [1:0][ADDR_W-1:0] ahost;
  assign cs = {sel(pb.primary_select_n, pb.secondary_select),
               sel(pa.primary_select_n, pa.secondary_select)};
  assign rwv = {pb.rw, pa.rw};
  assign oen = {pb.oe_n, pa.oe_n};
  assign adsn = {pb.address_strobe_n, pa.address_strobe_n};
  assign cntn = {pb.counter_advance_n, pa.counter_advance_n};
  assign clrn = {pb.counter_clear_n, pa.counter_clear_n};
  assign cms = {pb.counter_or_mask_select, pa.counter_or_mask_select};
  assign rbk = {pb.readback, pa.readback};
  assign ahost = {pb.addr_host, pa.addr_host};
  assign din = {pb.dq_host, pa.dq_host};
  assign lane_n = {{pb.byte_lane_select_high_n, pb.byte_lane_select_low_n},
                   {pa.byte_lane_select_high_n, pa.byte_lane_select_low_n}};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      logic [ADDR_W-1:0] amask;
      assign amask = mask_ff[g] & ADDR_W'((1 << AW) - 1);
      // Counter clear wins; strobe loads; advance increments within mask.
      always_comb begin
        if (!clrn[g]) begin
          acc[g] = '0;
        end else if (!adsn[g] && cms[g]) begin
          acc[g] = ahost[g] & ADDR_W'((1 << AW) - 1);
        end else begin
          acc[g] = cnt_ff[g];
        end
      end
      // A write right after a read with outputs enabled is swallowed.
      assign we[g] = cs[g] && !rwv[g] && (prev_we_ff[g] || oen[g]);

      always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
          cnt_ff[g] <= '0;
          load_ff[g] <= '0;
          wrap_n_ff[g] <= 1'b1;
        end else begin
          if (!clrn[g]) begin
            cnt_ff[g] <= '0;
            load_ff[g] <= '0;
          end else if (!adsn[g] && cms[g]) begin
            cnt_ff[g] <= acc[g];
            load_ff[g] <= acc[g];
          end else if (!cntn[g] && cs[g]) begin
            // Masked bits hold, unmasked bits count and wrap to loaded value.
            if ((cnt_ff[g] & amask) == amask) begin
              cnt_ff[g] <= (cnt_ff[g] & ~amask) | (load_ff[g] & amask);
            end else begin
              cnt_ff[g] <= (cnt_ff[g] & ~amask) | ((cnt_ff[g] + 1'b1) & amask);
            end
          end
          // Flag only when the counter really steps onto the top; deselect leaves it alone, clear or any strobe releases it.
          if (clrn[g] && adsn[g] && !cntn[g] && cs[g] &&
              (((cnt_ff[g] + 1'b1) & amask) == amask)) begin
            wrap_n_ff[g] <= 1'b0;
          end else if (!adsn[g] || !clrn[g]) begin
            wrap_n_ff[g] <= 1'b1;
          end
        end
      end

      always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
          mask_ff[g] <= MASK_RESET;
        end else if (!adsn[g] && !cms[g] && !rbk[g]) begin
          mask_ff[g] <= ahost[g];
        end
      end

      // Output pipeline: state in a cycle comes from last cycle's controls.
      always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
          rd_ff[g] <= 1'b0;
          prev_we_ff[g] <= 1'b0;
          dout_ff[g] <= '0;
          rb_ff[g] <= 1'b0;
          rb_val_ff[g] <= '0;
        end else begin
          rd_ff[g] <= cs[g] && rwv[g];
          prev_we_ff[g] <= cs[g] && !rwv[g];
          if (cs[g] && rwv[g]) begin
            dout_ff[g] <= mem[acc[g]];
          end
          rb_ff[g] <= rbk[g];
          rb_val_ff[g] <= cms[g] ? cnt_ff[g] : mask_ff[g];
        end
      end
    end
  endgenerate

  // Each port writes only its own address and lanes; on a dual same-address write port B's lanes win.
  always_ff @(posedge i_clk) begin
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        if (we[p] && !lane_n[p][l]) begin
          mem[acc[p]][l*LANE_W +: LANE_W] <= din[p][l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Mailbox: A's write sets, B's read clears; set wins over clear.
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      mail_n_ff <= 1'b1;
    end else if (we[0] && acc[0] == MAILBOX_ADDR && lane_n[0] != 2'b11) begin
      mail_n_ff <= 1'b0;
    end else if (cs[1] && rwv[1] && acc[1] == MAILBOX_ADDR) begin
      mail_n_ff <= 1'b1;
    end
  end

  assign pa.dq_dev = dout_ff[0];
  assign pb.dq_dev = dout_ff[1];
  assign pa.dq_dev_oe = rd_ff[0] && !pa.oe_n;
  assign pb.dq_dev_oe = rd_ff[1] && !pb.oe_n;
  assign pa.addr_dev = rb_val_ff[0];
  assign pb.addr_dev = rb_val_ff[1];
  assign pa.addr_dev_oe = rb_ff[0];
  assign pb.addr_dev_oe = rb_ff[1];
  assign pa.wrap_flag_n = wrap_n_ff[0];
  assign pb.wrap_flag_n = wrap_n_ff[1];
  assign pa.mail_flag_n = 1'b1;
  assign pb.mail_flag_n = mail_n_ff;
endmodule : dpram_core

//--- hw/dpram_host.sv
// Host controller for one RAM port: one access, readback or counter step per command.
// Assumes the port pins through dpram_if.host and one shared clock.
`timescale 1ns/1ps
module dpram_host
  import dpram_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_req, // Command pulse
  input wire logic i_wr, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] i_addr, // Word address
  input wire logic [DATA_W-1:0] i_wdata, // Write word
  input wire logic [1:0] i_lanes, // Byte lanes to write, high active
  input wire logic i_readback, // Readback request instead of access
  input wire logic i_rb_cnt, // Readback counter (1) or mask (0)
  input wire logic [1:0] i_count, // Counter use: 0 load, 1 advance, 2 clear, 3 mask load
  output logic o_busy, // Command in progress
  output logic o_done, // Command finished pulse
  output logic [DATA_W-1:0] o_rdata, // Read or readback word
  dpram_if.host p // Port pins
);
  host_state_t state_ff;
  logic wr_ff, rb_ff, done_ff;
  logic [1:0] lanes_ff, count_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= HOST_IDLE;
      done_ff <= 1'b0;
      rdata_ff <= '0;
      wr_ff <= 1'b0;
      rb_ff <= 1'b0;
      lanes_ff <= 2'h0;
      count_ff <= 2'h0;
      addr_ff <= '0;
      wdata_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        HOST_IDLE: begin
          if (i_req) begin
            state_ff <= HOST_ACCESS;
            wr_ff <= i_wr;
            rb_ff <= i_readback;
            // A write keeps at least one lane live so mailbox writes register.
            lanes_ff <= (i_lanes == 2'h0) ? 2'h1 : i_lanes;
            addr_ff <= i_addr;
            wdata_ff <= i_wdata;
            count_ff <= i_count;
          end
        end
        HOST_ACCESS: state_ff <= HOST_TURN;
        HOST_TURN: begin
          state_ff <= HOST_IDLE;
          done_ff <= 1'b1;
          if (rb_ff) begin
            rdata_ff <= DATA_W'(p.addr_dev);
          end else if (!wr_ff) begin
            rdata_ff <= p.dq_dev;
          end
        end
        default: state_ff <= HOST_IDLE;
      endcase
    end
  end

  // Write holds two cycles with outputs disabled so the first edge is not wasted.
  logic act;
  assign act = state_ff != HOST_IDLE;
  assign p.primary_select_n = !(state_ff == HOST_ACCESS || (act && wr_ff && !rb_ff));
  assign p.secondary_select = 1'b1;
  assign p.rw = !(act && wr_ff && !rb_ff);
  assign p.oe_n = act && wr_ff;
  // Advance only on reads: a write stays selected two cycles and would land twice.
  assign p.address_strobe_n = !(state_ff == HOST_ACCESS && !rb_ff &&
                                (count_ff == 2'h0 || count_ff == 2'h3));
  assign p.counter_advance_n = !(state_ff == HOST_ACCESS && !wr_ff && count_ff == 2'h1);
  assign p.counter_clear_n = !(state_ff == HOST_ACCESS && count_ff == 2'h2);
  assign p.counter_or_mask_select = rb_ff ? i_rb_cnt : (count_ff != 2'h3);
  assign p.byte_lane_select_low_n = !(act && lanes_ff[0]);
  assign p.byte_lane_select_high_n = !(act && lanes_ff[1]);
  assign p.global_reset_n = i_rst_b;
  assign p.readback = act && rb_ff;
  assign p.addr_host = addr_ff;
  // Keep off the address bus until the device has let go of it after readback.
  assign p.addr_host_oe = !(act && rb_ff) && !p.addr_dev_oe;
  assign p.dq_host = wdata_ff;
  assign p.dq_host_oe = act && wr_ff && !rb_ff;
  assign o_busy = act;
  assign o_done = done_ff;
  assign o_rdata = rdata_ff;
endmodule : dpram_host

//--- dv/dpram_assertions.sv
// Checker on the port A pins of the dual-port RAM.
// Assumes one clock and the bench's asynchronous active-low reset.
`timescale 1ns/1ps
module dpram_assertions (
  input wire logic i_clk, // Clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic primary_select_n, // Select, low active
  input wire logic secondary_select, // Select, high active
  input wire logic rw, // 1 read
  input wire logic oe_n, // Output enable
  input wire logic address_strobe_n, // Load strobe
  input wire logic counter_advance_n, // Counter advance
  input wire logic counter_or_mask_select, // Counter or mask
  input wire logic readback, // Readback request
  input wire logic addr_host_oe, // Host address drive
  input wire logic dq_host_oe, // Host data drive
  input wire logic addr_dev_oe, // Device address drive
  input wire logic dq_dev_oe, // Device data drive
  input wire logic wrap_flag_n // Wrap flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire sel = !primary_select_n && secondary_select;
  sequence s_read;
    sel && rw && !readback ##1 !oe_n;
  endsequence
  chk_read_drive: assert property (s_read |-> dq_dev_oe)
    else $error("read word not driven");
  chk_desel_float: assert property (!sel |=> !dq_dev_oe)
    else $error("data pins driven after deselect");
  chk_oe_async: assert property (oe_n |-> !dq_dev_oe)
    else $error("data pins driven with output enable off");
  chk_write_float: assert property (sel && !rw |=> !dq_dev_oe)
    else $error("data pins driven after write cycle");
  chk_drive_cause: assert property (dq_dev_oe |-> $past(sel && rw))
    else $error("data drive without selected read");
  chk_readback_drive: assert property (addr_dev_oe == $past(readback))
    else $error("address drive does not follow readback");
  chk_wrap_cause: assert property ($fell(wrap_flag_n) |-> $past(!counter_advance_n))
    else $error("wrap flag set without advance");
  chk_load_clear: assert property (sel && !address_strobe_n && counter_or_mask_select
    |=> wrap_flag_n)
    else $error("wrap flag kept over load");
  chk_addr_no_clash: assert property (!(addr_host_oe && addr_dev_oe))
    else $error("address pins driven from both ends");
  chk_data_no_clash: assert property (!(dq_host_oe && dq_dev_oe))
    else $error("data pins driven from both ends");
endmodule : dpram_assertions

//--- dv/tb_dpram_core.sv
// Testbench: RAM core with one host controller on each port.
// Assumes the checker watches port A; expectations come from a bench model.
`timescale 1ns/1ps
module tb_dpram_core;
  import dpram_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic req [2], wr [2], rb [2], rc [2], busy [2], done [2];
  logic [ADDR_W-1:0] ad [2];
  logic [DATA_W-1:0] wd [2], rd [2];
  logic [1:0] ln [2], ct [2];
  logic [ADDR_W-1:0] a, a2;
  logic [DATA_W-1:0] d, d2, e, q, q2;
  int num_errors = 0;
  int tests_run = 0;
  dpram_if ifa ();
  dpram_if ifb ();
  dpram_core #(.AW(ADDR_W)) i_dpram_core (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .pa(ifa.device), .pb(ifb.device));
  dpram_host i_dpram_host_a (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req[0]), .i_wr(wr[0]),
    .i_addr(ad[0]), .i_wdata(wd[0]), .i_lanes(ln[0]), .i_readback(rb[0]), .i_rb_cnt(rc[0]),
    .i_count(ct[0]), .o_busy(busy[0]), .o_done(done[0]), .o_rdata(rd[0]), .p(ifa.host));
  dpram_host i_dpram_host_b (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req[1]), .i_wr(wr[1]),
    .i_addr(ad[1]), .i_wdata(wd[1]), .i_lanes(ln[1]), .i_readback(rb[1]), .i_rb_cnt(rc[1]),
    .i_count(ct[1]), .o_busy(busy[1]), .o_done(done[1]), .o_rdata(rd[1]), .p(ifb.host));
  dpram_assertions i_dpram_assertions (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .primary_select_n(ifa.primary_select_n), .secondary_select(ifa.secondary_select),
    .rw(ifa.rw), .oe_n(ifa.oe_n), .address_strobe_n(ifa.address_strobe_n),
    .counter_advance_n(ifa.counter_advance_n), .readback(ifa.readback),
    .counter_or_mask_select(ifa.counter_or_mask_select), .addr_dev_oe(ifa.addr_dev_oe),
    .addr_host_oe(ifa.addr_host_oe), .dq_host_oe(ifa.dq_host_oe),
    .dq_dev_oe(ifa.dq_dev_oe), .wrap_flag_n(ifa.wrap_flag_n));
  initial forever #4 i_clk = ~i_clk;
  // Lane 0 stands in for an empty lane set, as the host does
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
      input logic [1:0] l);
    logic [1:0] s;
    s = (l == 2'h0) ? 2'h1 : l;
    return {s[1] ? n[DATA_W-1:LANE_W] : o[DATA_W-1:LANE_W], s[0] ? n[LANE_W-1:0] : o[LANE_W-1:0]};
  endfunction : merge
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic access(input int h, input logic w, input logic [ADDR_W-1:0] x,
      input logic [DATA_W-1:0] v, input logic [1:0] l, input logic b, input logic c,
      output logic [DATA_W-1:0] r, input logic [1:0] k = 2'h0);
    int n;
    n = 0;
    @(posedge i_clk);
    req[h] <= 1'b1;
    wr[h] <= w;
    ad[h] <= x;
    wd[h] <= v;
    ln[h] <= l;
    rb[h] <= b;
    rc[h] <= c;
    ct[h] <= k;
    @(posedge i_clk);
    req[h] <= 1'b0;
    #1;
    check(busy[h], 1'b1);
    while (done[h] !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(done[h], 1'b1);
    r = rd[h];
  endtask : access
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    #160000;
    num_errors++;
    end_of_test();
  end
  initial begin
    for (int h = 0; h < 2; h++) begin
      {req[h], wr[h], rb[h], rc[h], ad[h], wd[h], ln[h], ct[h]} = '0;
    end
    void'($urandom(44));
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    check(ifa.wrap_flag_n, 1'b1);
    check(ifb.mail_flag_n, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      a = 18'($urandom % WRAP_ADDR_LO);
      d = 18'($urandom);
      access(0, 1'b1, a, d, 2'h3, 1'b0, 1'b0, q);
      access(1, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q);
      check(q, d);
      access(0, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q);
      check(q, d);
    end
    $display("test cross port done");
    e = d;
    for (int l = 0; l < 3; l++) begin
      d2 = 18'($urandom);
      access(0, 1'b1, a, d2, 2'(l), 1'b0, 1'b0, q);
      e = merge(e, d2, 2'(l));
      access(1, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q);
      check(q, e);
    end
    $display("test lanes done");
    a2 = a ^ 18'h00001;
    fork
      access(0, 1'b1, a, d, 2'h3, 1'b0, 1'b0, q);
      access(1, 1'b1, a2, d2, 2'h3, 1'b0, 1'b0, q2);
    join
    access(1, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q);
    access(0, 1'b0, a2, '0, 2'h0, 1'b0, 1'b0, q2);
    check(q, d);
    check(q2, d2);
    $display("test dual write done");
    access(0, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q);
    access(0, 1'b0, a, '0, 2'h0, 1'b1, 1'b1, q);
    check(q, a);
    access(0, 1'b0, a, '0, 2'h0, 1'b1, 1'b0, q);
    check(q, MASK_RESET);
    $display("test readback done");
    // One lane stays active while the mailbox is set and cleared
    access(0, 1'b1, MAILBOX_ADDR, d, 2'h1, 1'b0, 1'b0, q);
    check(ifb.mail_flag_n, 1'b0);
    access(1, 1'b0, MAILBOX_ADDR, '0, 2'h1, 1'b0, 1'b0, q);
    check(ifb.mail_flag_n, 1'b1);
    $display("test mailbox done");
    // Counter walk: step to the top address, wrap to the loaded start, replay it, clear
    e = d ^ d2;
    access(0, 1'b1, 18'h00000, e, 2'h3, 1'b0, 1'b0, q);
    access(0, 1'b1, WRAP_ADDR_HI, d, 2'h3, 1'b0, 1'b0, q);
    access(0, 1'b1, WRAP_ADDR_LO, d2, 2'h3, 1'b0, 1'b0, q);
    check(ifa.wrap_flag_n, 1'b1);
    access(0, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q, 2'h1);
    check(q, d2);
    check(ifa.wrap_flag_n, 1'b0);
    access(0, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q, 2'h1);
    check(q, d);
    access(0, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q, 2'h1);
    check(q, d2);
    access(0, 1'b0, a, '0, 2'h0, 1'b0, 1'b0, q, 2'h2);
    check(q, e);
    check(ifa.wrap_flag_n, 1'b1);
    $display("test counter done");
    a2 = 18'($urandom);
    access(0, 1'b0, a2, '0, 2'h0, 1'b0, 1'b0, q, 2'h3);
    access(0, 1'b0, a, '0, 2'h0, 1'b1, 1'b0, q);
    check(q, a2);
    check(ifb.mail_flag_n, 1'b0);
    // A mid-run reset must drop the mailbox flag and restore the mask
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check(ifb.mail_flag_n, 1'b1);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    access(0, 1'b0, a, '0, 2'h0, 1'b1, 1'b0, q);
    check(q, MASK_RESET);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : tb_dpram_core
